// [design/ctm_cmd_decode.sv]
`timescale 1ns/1ps
module ctm_cmd_decode (
    // selector fields
    input  wire logic [3:0]        regNum,
    input  wire logic [2:0]        opc2,
    input  wire logic [3:0]        minor,
    input  wire logic              isWrite,
    // decoded result
    output ctm_pkg::ctm_cmd_t      cmdVec,
    output logic                   selCause,
    output logic                   selAddr,
    output logic                   selLock,
    output logic                   reserved
);
    function automatic logic [10:0] key(input logic [3:0] r,
                                        input logic [2:0] o,
                                        input logic [3:0] m);
        key = {r, o, m};
    endfunction

    function automatic ctm_pkg::ctm_cmd_t decode(input logic [10:0] k);
        decode = '0;
        case (k)
            key(ctm_pkg::CRN_CACHE, ctm_pkg::OP_0, ctm_pkg::MIN_BOTH):
                decode[ctm_pkg::CMD_INV_IDB] = 1'b1;
            key(ctm_pkg::CRN_CACHE, ctm_pkg::OP_0, ctm_pkg::MIN_I):
                decode[ctm_pkg::CMD_INV_IB] = 1'b1;
            key(ctm_pkg::CRN_CACHE, ctm_pkg::OP_0, ctm_pkg::MIN_D):
                decode[ctm_pkg::CMD_INV_D] = 1'b1;
            key(ctm_pkg::CRN_CACHE, ctm_pkg::OP_1, ctm_pkg::MIN_I):
                decode[ctm_pkg::CMD_INV_ILINE] = 1'b1;
            key(ctm_pkg::CRN_CACHE, ctm_pkg::OP_1, ctm_pkg::MIN_D):
                decode[ctm_pkg::CMD_INV_DLINE] = 1'b1;
            key(ctm_pkg::CRN_CACHE, ctm_pkg::OP_1, ctm_pkg::MIN_CLEAN):
                decode[ctm_pkg::CMD_CLEAN] = 1'b1;
            key(ctm_pkg::CRN_CACHE, ctm_pkg::OP_4, ctm_pkg::MIN_CLEAN):
                decode[ctm_pkg::CMD_DRAIN] = 1'b1;
            key(ctm_pkg::CRN_CACHE, ctm_pkg::OP_6, ctm_pkg::MIN_I):
                decode[ctm_pkg::CMD_INV_BPB] = 1'b1;
            key(ctm_pkg::CRN_CACHE, ctm_pkg::OP_5, ctm_pkg::MIN_DLOCK):
                decode[ctm_pkg::CMD_ALLOC] = 1'b1;
            key(ctm_pkg::CRN_TLB, ctm_pkg::OP_0, ctm_pkg::MIN_BOTH):
                decode[ctm_pkg::CMD_TLB_ALL] = 1'b1;
            key(ctm_pkg::CRN_TLB, ctm_pkg::OP_0, ctm_pkg::MIN_I):
                decode[ctm_pkg::CMD_ITLB] = 1'b1;
            key(ctm_pkg::CRN_TLB, ctm_pkg::OP_1, ctm_pkg::MIN_I):
                decode[ctm_pkg::CMD_ITLB_ENT] = 1'b1;
            key(ctm_pkg::CRN_TLB, ctm_pkg::OP_0, ctm_pkg::MIN_D):
                decode[ctm_pkg::CMD_DTLB] = 1'b1;
            key(ctm_pkg::CRN_TLB, ctm_pkg::OP_1, ctm_pkg::MIN_D):
                decode[ctm_pkg::CMD_DTLB_ENT] = 1'b1;
            key(ctm_pkg::CRN_CLOCK, ctm_pkg::OP_0, ctm_pkg::MIN_ILOCK):
                decode[ctm_pkg::CMD_LOCK_IL] = 1'b1;
            key(ctm_pkg::CRN_CLOCK, ctm_pkg::OP_1, ctm_pkg::MIN_ILOCK):
                decode[ctm_pkg::CMD_UNLOCK_I] = 1'b1;
            key(ctm_pkg::CRN_CLOCK, ctm_pkg::OP_1, ctm_pkg::MIN_DLOCK):
                decode[ctm_pkg::CMD_UNLOCK_D] = 1'b1;
            key(ctm_pkg::CRN_TLOCK, ctm_pkg::OP_0, ctm_pkg::MIN_ITLB):
                decode[ctm_pkg::CMD_LOCK_IT] = 1'b1;
            key(ctm_pkg::CRN_TLOCK, ctm_pkg::OP_0, ctm_pkg::MIN_DTLB):
                decode[ctm_pkg::CMD_LOCK_DT] = 1'b1;
            key(ctm_pkg::CRN_TLOCK, ctm_pkg::OP_1, ctm_pkg::MIN_ITLB):
                decode[ctm_pkg::CMD_UNLOCK_IT] = 1'b1;
            key(ctm_pkg::CRN_TLOCK, ctm_pkg::OP_1, ctm_pkg::MIN_DTLB):
                decode[ctm_pkg::CMD_UNLOCK_DT] = 1'b1;
            default:
                decode = '0;
        endcase
    endfunction

    logic maintReg;

    always_comb begin
        cmdVec   = isWrite ? decode(key(regNum, opc2, minor)) : '0;
        selCause = (regNum == ctm_pkg::CRN_CAUSE);
        selAddr  = (regNum == ctm_pkg::CRN_ADDR);
        selLock  = (regNum == ctm_pkg::CRN_CLOCK)
                && (opc2 == ctm_pkg::OP_0)
                && (minor == ctm_pkg::MIN_DLOCK);
        maintReg = (regNum >= ctm_pkg::CRN_CACHE)
                && (regNum <= ctm_pkg::CRN_TLOCK);
        // reads of write-only selectors are undefined, not reserved
        if (isWrite) begin
            reserved = (cmdVec == '0) && !selCause && !selAddr
                    && !selLock;
        end else begin
            reserved = !(selCause || selAddr || maintReg);
        end
    end
endmodule

// [design/ctm_maint_ctrl.sv]
`timescale 1ns/1ps
module ctm_maint_ctrl (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // coprocessor transfer request
    input  wire logic              cpValid,
    input  wire logic              cpWrite,
    input  wire logic [3:0]        cpRegNum,
    input  wire logic [2:0]        cpOpc2,
    input  wire logic [3:0]        cpMinor,
    input  wire logic [31:0]       cpWdata,
    // coprocessor answer
    output logic [31:0]            cpRdata,
    output logic                   cpRdValid,
    output logic                   cpBusy,
    output logic                   cpReserved,
    // abort capture
    input  wire logic              abortValid,
    input  wire logic              abortData,
    input  wire logic              abortDebug,
    input  wire logic              abortExt,
    input  wire logic [3:0]        abortDomain,
    input  wire logic [3:0]        abortStatus,
    input  wire logic [31:0]       abortAddr,
    // cache and tlb commands
    output ctm_pkg::ctm_cmd_t      cmdStrobe,
    output logic [31:0]            cmdAddr,
    // line allocate and parity handshake
    output logic                   drainReq,
    input  wire logic              memIdle,
    input  wire logic              lineResident,
    input  wire logic              cleanParityErr,
    output logic                   parityFault,
    // lock mode and fault registers
    output logic                   dcacheLockMode,
    output logic [31:0]            faultCause,
    output logic [31:0]            faultAddress
);
    typedef struct packed {
        ctm_pkg::ctm_state_t st;
        logic                busy;
        logic [31:0]         cause;
        logic [31:0]         addr;
        logic                lockMode;
        ctm_pkg::ctm_cmd_t   strobe;
        logic [31:0]         cmdAddr;
        logic [31:0]         rdata;
        logic                rdValid;
        logic                reserved;
        logic                drainReq;
        logic                parity;
    } ctm_regs_t;

    ctm_regs_t         state_reg;
    ctm_regs_t         state_next;
    ctm_pkg::ctm_cmd_t decCmd;
    logic              decCause;
    logic              decAddr;
    logic              decLock;
    logic              decReserved;
    logic              accept;

    // selector decode
    ctm_cmd_decode decoder (
        .regNum   (cpRegNum),
        .opc2     (cpOpc2),
        .minor    (cpMinor),
        .isWrite  (cpWrite),
        .cmdVec   (decCmd),
        .selCause (decCause),
        .selAddr  (decAddr),
        .selLock  (decLock),
        .reserved (decReserved)
    );

    function automatic logic [31:0] line_of(input logic [31:0] a);
        line_of = {a[31:ctm_pkg::LINE_LSB], {ctm_pkg::LINE_LSB{1'b0}}};
    endfunction

    assign accept = cpValid && !state_reg.busy;

    always_comb begin
        state_next          = state_reg;
        state_next.strobe   = '0;
        state_next.rdValid  = 1'b0;
        state_next.reserved = 1'b0;
        // a parity fault can only follow a clean data line
        state_next.parity   = cleanParityErr
                && state_reg.strobe[ctm_pkg::CMD_CLEAN];
        case (state_reg.st)
            ctm_pkg::ST_IDLE: begin
                if (accept && cpWrite) begin
                    state_next.reserved = decReserved;
                    if (decCmd[ctm_pkg::CMD_ALLOC]) begin
                        // hold off until memory is quiet
                        state_next.cmdAddr  = line_of(cpWdata);
                        state_next.drainReq = 1'b1;
                        state_next.st       = ctm_pkg::ST_DRAIN;
                    end else begin
                        // no enable gating and no fault generation
                        state_next.strobe  = decCmd;
                        state_next.cmdAddr = cpWdata;
                    end
                    if (decCause) begin
                        state_next.cause = cpWdata & ctm_pkg::FC_WMASK;
                    end
                    if (decAddr) begin
                        state_next.addr = cpWdata;
                    end
                    if (decLock) begin
                        state_next.lockMode =
                            cpWdata[ctm_pkg::LOCK_BIT];
                    end
                end else if (accept) begin
                    state_next.rdValid  = 1'b1;
                    state_next.reserved = decReserved;
                    if (decCause) begin
                        state_next.rdata = state_reg.cause;
                    end else if (decAddr) begin
                        state_next.rdata = state_reg.addr;
                    end else if (decLock) begin
                        state_next.rdata = {31'h0000_0000,
                                            state_reg.lockMode};
                    end else begin
                        state_next.rdata = 32'h0000_0000;
                    end
                end
            end
            ctm_pkg::ST_DRAIN: begin
                if (memIdle) begin
                    state_next.drainReq = 1'b0;
                    state_next.st       = ctm_pkg::ST_ALLOC;
                end
            end
            ctm_pkg::ST_ALLOC: begin
                // a resident line is left alone
                state_next.strobe[ctm_pkg::CMD_ALLOC] =
                    !lineResident;
                state_next.st = ctm_pkg::ST_IDLE;
            end
            default: begin
                state_next.st       = ctm_pkg::ST_IDLE;
                state_next.drainReq = 1'b0;
            end
        endcase
        // abort capture wins over a software cause write in the same cycle, and over an address write only on a data abort
        if (abortValid) begin
            state_next.cause = ctm_pkg::FC_RESET;
            state_next.cause[ctm_pkg::FC_EXT] = abortExt;
            state_next.cause[ctm_pkg::FC_DBG] = abortDebug;
            state_next.cause[ctm_pkg::FC_STAHI:ctm_pkg::FC_STALO] =
                abortStatus;
            state_next.cause[ctm_pkg::FC_DOMHI:ctm_pkg::FC_DOMLO] =
                abortData ? abortDomain
                : state_reg.cause[ctm_pkg::FC_DOMHI:ctm_pkg::FC_DOMLO];
            if (abortData) begin
                state_next.addr = abortAddr;
            end
        end
        state_next.busy = (state_next.st != ctm_pkg::ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.st       <= ctm_pkg::ST_IDLE;
            state_reg.busy     <= 1'b0;
            state_reg.cause    <= ctm_pkg::FC_RESET;
            state_reg.addr     <= ctm_pkg::FA_RESET;
            state_reg.lockMode <= ctm_pkg::LOCK_RESET;
            state_reg.strobe   <= '0;
            state_reg.cmdAddr  <= 32'h0000_0000;
            state_reg.rdata    <= 32'h0000_0000;
            state_reg.rdValid  <= 1'b0;
            state_reg.reserved <= 1'b0;
            state_reg.drainReq <= 1'b0;
            state_reg.parity   <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    assign cpRdata        = state_reg.rdata;
    assign cpRdValid      = state_reg.rdValid;
    assign cpBusy         = state_reg.busy;
    assign cpReserved     = state_reg.reserved;
    assign cmdStrobe      = state_reg.strobe;
    assign cmdAddr        = state_reg.cmdAddr;
    assign drainReq       = state_reg.drainReq;
    assign parityFault    = state_reg.parity;
    assign dcacheLockMode = state_reg.lockMode;
    assign faultCause     = state_reg.cause;
    assign faultAddress   = state_reg.addr;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sAllocTaken;
        accept && cpWrite && decCmd[ctm_pkg::CMD_ALLOC];
    endsequence

    sequence sDrainDone;
        state_reg.st == ctm_pkg::ST_DRAIN && memIdle;
    endsequence

    sequence sWriteTaken;
        accept && cpWrite;
    endsequence

    cause_status_a: assert property (
        abortValid |=> faultCause[3:0] == $past(abortStatus))
        else $error("fault status not loaded on abort");

    ext_bit_a: assert property (
        abortValid |=> faultCause[ctm_pkg::FC_EXT] == $past(abortExt))
        else $error("extension bit not loaded on abort");

    debug_bit_a: assert property (
        abortValid |=> faultCause[ctm_pkg::FC_DBG] == $past(abortDebug))
        else $error("debug bit not loaded on abort");

    domain_field_a: assert property (
        abortValid && abortData
        |=> faultCause[7:4] == $past(abortDomain))
        else $error("domain not recorded on data abort");

    fault_addr_a: assert property (
        abortValid && abortData |=> faultAddress == $past(abortAddr))
        else $error("fault address not loaded on data abort");

    drain_cmd_a: assert property (
        sWriteTaken and (cpRegNum == ctm_pkg::CRN_CACHE
            && cpOpc2 == ctm_pkg::OP_4 && cpMinor == ctm_pkg::MIN_CLEAN)
        |=> cmdStrobe[ctm_pkg::CMD_DRAIN] && $onehot(cmdStrobe))
        else $error("drain command not issued alone");

    alloc_start_a: assert property (
        sAllocTaken |=> drainReq && cpBusy
            && cmdStrobe == '0 && cmdAddr[4:0] == 5'h00)
        else $error("allocate did not wait for memory");

    alloc_finish_a: assert property (
        sDrainDone |=> !drainReq ##1
            (cmdStrobe[ctm_pkg::CMD_ALLOC] == !$past(lineResident))
            && !cpBusy)
        else $error("allocate issue or resident skip wrong");

    bpb_spared_a: assert property (
        cmdStrobe[ctm_pkg::CMD_INV_ILINE]
        |-> !cmdStrobe[ctm_pkg::CMD_INV_BPB]
            && !cmdStrobe[ctm_pkg::CMD_INV_IB])
        else $error("line invalidate touched predictor");

    parity_src_a: assert property (
        parityFault |-> $past(cmdStrobe[ctm_pkg::CMD_CLEAN]))
        else $error("parity fault without clean line");

    lock_write_a: assert property (
        sWriteTaken and decLock and !abortValid
        |=> dcacheLockMode == $past(cpWdata[0]))
        else $error("lock mode bit not written");

    lock_read_a: assert property (
        accept && !cpWrite && decLock
        |=> cpRdValid && cpRdata == {31'h0000_0000, dcacheLockMode})
        else $error("lock mode read back wrong");

    reserved_op_a: assert property (
        sWriteTaken and decReserved
        |=> cpReserved && cmdStrobe == '0 && !cpBusy)
        else $error("reserved operation had an effect");

    sequence sReadTaken;
        accept && !cpWrite;
    endsequence

    sequence sAddrWrite;
        accept && cpWrite && decAddr && !abortValid;
    endsequence

    sequence sCauseWrite;
        accept && cpWrite && decCause && !abortValid;
    endsequence

    read_answer_a: assert property (
        sReadTaken |=> cpRdValid && cmdStrobe == '0)
        else $error("read not answered alone");

    write_silent_a: assert property (
        sWriteTaken |=> !cpRdValid)
        else $error("write gave read answer");

    reserved_read_a: assert property (
        sReadTaken and decReserved
        |=> cpReserved && cpRdata == 32'h0000_0000)
        else $error("reserved read not flagged");

    strobe_onehot_a: assert property (
        $onehot0(cmdStrobe))
        else $error("more than one command strobe");

    busy_quiet_a: assert property (
        cpBusy |=> !cpRdValid && !cpReserved)
        else $error("request taken while busy");

    drain_strobe_a: assert property (
        drainReq |-> cpBusy && cmdStrobe == '0)
        else $error("command issued while draining");

    drain_hold_a: assert property (
        drainReq && !memIdle |=> drainReq)
        else $error("drain request dropped early");

    addr_write_a: assert property (
        sAddrWrite |=> faultAddress == $past(cpWdata))
        else $error("fault address not written");

    cause_write_a: assert property (
        sCauseWrite
        |=> faultCause == ($past(cpWdata) & ctm_pkg::FC_WMASK))
        else $error("fault cause write mask wrong");

    cause_upper_a: assert property (
        abortValid |=> faultCause[31:11] == '0 && !faultCause[8])
        else $error("fault cause not fully reloaded");

    prefetch_dom_a: assert property (
        abortValid && !abortData
        |=> faultCause[7:4] == $past(faultCause[7:4]))
        else $error("prefetch abort changed domain");

    prefetch_addr_a: assert property (
        abortValid && !abortData && !(accept && cpWrite && decAddr)
        |=> $stable(faultAddress))
        else $error("prefetch abort changed address");

    lock_hold_a: assert property (
        !(accept && cpWrite && decLock) |=> $stable(dcacheLockMode))
        else $error("lock mode changed unasked");

    cmd_addr_a: assert property (
        sWriteTaken and (decCmd != '0 && !decCmd[ctm_pkg::CMD_ALLOC])
        |=> cmdAddr == $past(cpWdata))
        else $error("command operand not passed");

    parity_quiet_a: assert property (
        !cmdStrobe[ctm_pkg::CMD_CLEAN] |=> !parityFault)
        else $error("parity fault after other command");
endmodule

// [design/ctm_pkg.sv]
// Notes on behaviour
// - abort entry reloads fault cause, no clearing
// - cause bit 10 extends status encoding
// - cause bit 9 marks debug-caused abort
// - data abort records domain in 7:4
// - fault status recorded in bits 3:0
// - drain empties write and fill buffers
// - maintenance never raises translation faults
// - instruction line invalidate spares predictor
// - commands run regardless of cache enable
// - only clean data line may parity-fault
// - whole-cache invalidates on opcode zero
// - single-line invalidates and clean by address
// - predictor-only invalidate ignores operand
// - line allocate installs tag from 31:5
// - allocate drains pending ops, line clean
// - resident line: allocate drains, then issues no strobe
// - tlb commands run regardless of translation
// - tlb invalidates whole, entry, both sides
// - fetch-lock and unlock instruction cache
// - lock mode locks fills; unlock releases
// - only lock mode bit reads back
// - translate-lock and unlock tlb entries
package ctm_pkg;
    // primary register numbers
    localparam logic [3:0] CRN_CAUSE = 4'h5;
    localparam logic [3:0] CRN_ADDR  = 4'h6;
    localparam logic [3:0] CRN_CACHE = 4'h7;
    localparam logic [3:0] CRN_TLB   = 4'h8;
    localparam logic [3:0] CRN_CLOCK = 4'h9;
    localparam logic [3:0] CRN_TLOCK = 4'hA;
    // secondary opcodes
    localparam logic [2:0] OP_0 = 3'h0;
    localparam logic [2:0] OP_1 = 3'h1;
    localparam logic [2:0] OP_4 = 3'h4;
    localparam logic [2:0] OP_5 = 3'h5;
    localparam logic [2:0] OP_6 = 3'h6;
    // minor register selectors
    localparam logic [3:0] MIN_ILOCK = 4'h1;
    localparam logic [3:0] MIN_DLOCK = 4'h2;
    localparam logic [3:0] MIN_ITLB  = 4'h4;
    localparam logic [3:0] MIN_I     = 4'h5;
    localparam logic [3:0] MIN_D     = 4'h6;
    localparam logic [3:0] MIN_BOTH  = 4'h7;
    localparam logic [3:0] MIN_DTLB  = 4'h8;
    localparam logic [3:0] MIN_CLEAN = 4'hA;
    // fault cause fields, line offset and lock mode bit
    localparam int FC_EXT   = 10;
    localparam int FC_DBG   = 9;
    localparam int FC_DOMHI = 7;
    localparam int FC_DOMLO = 4;
    localparam int FC_STAHI = 3;
    localparam int FC_STALO = 0;
    localparam logic [31:0] FC_WMASK = 32'h0000_06FF;
    localparam int LINE_LSB = 5;
    localparam int LOCK_BIT = 0;
    // reset values
    localparam logic [31:0] FC_RESET   = 32'h0000_0000;
    localparam logic [31:0] FA_RESET   = 32'h0000_0000;
    localparam logic        LOCK_RESET = 1'h0;
    // command strobe positions
    localparam int CMD_INV_IDB   = 0;
    localparam int CMD_INV_IB    = 1;
    localparam int CMD_INV_ILINE = 2;
    localparam int CMD_INV_D     = 3;
    localparam int CMD_INV_DLINE = 4;
    localparam int CMD_CLEAN     = 5;
    localparam int CMD_DRAIN     = 6;
    localparam int CMD_INV_BPB   = 7;
    localparam int CMD_ALLOC     = 8;
    localparam int CMD_TLB_ALL   = 9;
    localparam int CMD_ITLB      = 10;
    localparam int CMD_ITLB_ENT  = 11;
    localparam int CMD_DTLB      = 12;
    localparam int CMD_DTLB_ENT  = 13;
    localparam int CMD_LOCK_IL   = 14;
    localparam int CMD_UNLOCK_I  = 15;
    localparam int CMD_UNLOCK_D  = 16;
    localparam int CMD_LOCK_IT   = 17;
    localparam int CMD_LOCK_DT   = 18;
    localparam int CMD_UNLOCK_IT = 19;
    localparam int CMD_UNLOCK_DT = 20;
    localparam int CMD_COUNT     = 21;
    typedef logic [CMD_COUNT-1:0] ctm_cmd_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_DRAIN = 3'h2,
        ST_ALLOC = 3'h4
    } ctm_state_t;
endpackage

// [sim/ctm_maint_ctrl_tb.sv]
`timescale 1ns/1ps
module ctm_maint_ctrl_tb;
    logic clk, rst, cpValid, cpWrite, cpRdValid, cpBusy, cpReserved;
    logic abortValid, abortData, abortDebug, abortExt, drainReq, memIdle;
    logic lineResident, cleanParityErr, parityFault, dcacheLockMode;
    logic resident, parityOn;
    logic [2:0] cpOpc2;
    logic [3:0] cpRegNum, cpMinor, abortDomain, abortStatus;
    logic [7:0] idleDelay;
    logic [31:0] cpWdata, cpRdata, abortAddr, cmdAddr;
    logic [31:0] faultCause, faultAddress;
    ctm_pkg::ctm_cmd_t cmdStrobe;
    int miscompares, checked;
    logic [19:0] tbl [20] = '{20'h70700, 20'h70501, 20'h71502, 20'h70603,
        20'h71604, 20'h71A05, 20'h74A06, 20'h76507, 20'h80709, 20'h8050A,
        20'h8150B, 20'h8060C, 20'h8160D, 20'h9010E, 20'h9110F, 20'h91210,
        20'hA0411, 20'hA0812, 20'hA1413, 20'hA1814};

    ctm_maint_ctrl DUT (.clk, .rst, .cpValid, .cpWrite, .cpRegNum, .cpOpc2,
        .cpMinor, .cpWdata, .cpRdata, .cpRdValid, .cpBusy, .cpReserved,
        .abortValid, .abortData, .abortDebug, .abortExt, .abortDomain,
        .abortStatus, .abortAddr, .cmdStrobe, .cmdAddr, .drainReq, .memIdle,
        .lineResident, .cleanParityErr, .parityFault, .dcacheLockMode,
        .faultCause, .faultAddress);
    ctm_mem_model mem (.clk, .rst, .drainReq, .cmdStrobe, .idleDelay,
        .resident, .parityOn, .memIdle, .lineResident, .cleanParityErr);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task end_of_test;
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // request held until the taking edge; returns just after it
    task op(input logic w, input logic [3:0] r, input logic [2:0] o,
            input logic [3:0] m, input logic [31:0] d);
        cpValid = 1'b1;
        cpWrite = w;
        cpRegNum = r;
        cpOpc2 = o;
        cpMinor = m;
        cpWdata = d;
        @(posedge clk);
        #1;
    endtask

    task abort(input logic d, input logic dbg, input logic ext,
               input logic [3:0] dom, input logic [3:0] st);
        abortValid = 1'b1;
        abortData = d;
        abortDebug = dbg;
        abortExt = ext;
        abortDomain = dom;
        abortStatus = st;
        @(posedge clk);
        #1;
    endtask

    task tick;
        cpValid = 1'b0;
        abortValid = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task t_abort;
        abortAddr = 32'hDEAD_BEE0;
        abort(1'b1, 1'b0, 1'b1, 4'hA, 4'h5);
        chk(faultCause, 32'h0000_04A5);
        chk(faultAddress, 32'hDEAD_BEE0);
        tick;
        abort(1'b0, 1'b1, 1'b0, 4'h3, 4'hC);
        chk(faultCause, 32'h0000_02AC);
        chk(faultAddress, 32'hDEAD_BEE0);
        tick;
        op(1'b0, 4'h5, 3'h0, 4'h0, 32'h0);
        chk({31'h0, cpRdValid}, 32'h1);
        chk(cpRdata, 32'h0000_02AC);
        op(1'b1, 4'h5, 3'h0, 4'h0, 32'hFFFF_FFFF);
        chk(faultCause, 32'h0000_06FF);
        op(1'b1, 4'h6, 3'h0, 4'h0, 32'h1357_9BDF);
        chk(faultAddress, 32'h1357_9BDF);
        tick;
    endtask

    task t_cmds;
        for (int i = 0; i < 20; i++) begin
            op(1'b1, tbl[i][19:16], tbl[i][14:12], tbl[i][11:8],
               32'h100 * i);
            chk({11'h0, cmdStrobe}, 32'h1 << tbl[i][7:0]);
            chk(cmdAddr, 32'h100 * i);
        end
        tick;
    endtask

    task t_reserved;
        op(1'b1, 4'h7, 3'h2, 4'h0, 32'h0);
        chk({cpReserved, 10'h0, cmdStrobe}, 32'h8000_0000);
        op(1'b1, 4'h8, 3'h1, 4'h7, 32'h0);
        chk({cpReserved, 10'h0, cmdStrobe}, 32'h8000_0000);
        op(1'b1, 4'hB, 3'h0, 4'h0, 32'h0);
        chk({cpReserved, 10'h0, cmdStrobe}, 32'h8000_0000);
        tick;
    endtask

    task t_lock;
        op(1'b1, 4'h9, 3'h0, 4'h2, 32'hFFFF_FFFF);
        chk({10'h0, dcacheLockMode, cmdStrobe}, 32'h0020_0000);
        op(1'b0, 4'h9, 3'h0, 4'h2, 32'h0);
        chk({cpRdValid, cpRdata[30:0]}, 32'h8000_0001);
        op(1'b1, 4'h9, 3'h0, 4'h2, 32'h0);
        chk({31'h0, dcacheLockMode}, 32'h0);
        tick;
    endtask

    task t_parity(input logic [2:0] o, input logic [31:0] exp);
        int n;
        n = 0;
        parityOn = 1'b1;
        op(1'b1, 4'h7, o, 4'hA, 32'h40);
        cpValid = 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            n += parityFault;
        end
        chk(n, exp);
        parityOn = 1'b0;
    endtask

    task t_alloc(input logic res, input logic [7:0] dly);
        int n;
        n = 0;
        resident = res;
        idleDelay = dly;
        op(1'b1, 4'h7, 3'h5, 4'h2, 32'hABCD_EF1F);
        cpValid = 1'b0;
        chk({cpBusy, drainReq}, 32'h3);
        chk(cmdAddr, 32'hABCD_EF00);
        while (cpBusy === 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 40) begin
            miscompares++;
            end_of_test;
        end
        chk(n, dly + 2);
        chk({11'h0, cmdStrobe}, res ? 32'h0 : 32'h100);
    endtask

    initial begin
        {cpValid, cpWrite, cpRegNum, cpOpc2, cpMinor, cpWdata} = '0;
        {abortValid, abortData, abortDebug, abortExt} = '0;
        {abortDomain, abortStatus, abortAddr} = '0;
        {resident, parityOn, idleDelay} = '0;
        miscompares = 0;
        checked = 0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        chk(faultCause | faultAddress, 32'h0);
        chk({31'h0, dcacheLockMode}, 32'h0);
        t_cmds;
        t_reserved;
        t_lock;
        t_abort;
        t_parity(3'h1, 32'h1);
        t_parity(3'h4, 32'h0);
        t_alloc(1'b0, 8'h05);
        t_alloc(1'b1, 8'h00);
        end_of_test;
    end
endmodule

// [sim/ctm_mem_model.sv]
`timescale 1ns/1ps
module ctm_mem_model (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // block side
    input  wire logic             drainReq,
    input  wire ctm_pkg::ctm_cmd_t cmdStrobe,
    // scenario controls
    input  wire logic [7:0]       idleDelay,
    input  wire logic             resident,
    input  wire logic             parityOn,
    // answers
    output logic                  memIdle,
    output logic                  lineResident,
    output logic                  cleanParityErr
);
    logic [7:0] cnt;
    // pending traffic drains only after idleDelay cycles
    always_ff @(posedge clk) begin
        if (rst || !drainReq) cnt <= 8'h00;
        else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
    end
    // parity answer stands with the clean strobe itself
    assign cleanParityErr = !rst && parityOn
        && cmdStrobe[ctm_pkg::CMD_CLEAN];
    assign memIdle = drainReq && (cnt >= idleDelay);
    assign lineResident = resident;
endmodule
